// ---- llec_consts.svh ----
`ifndef LLEC_CONSTS_SVH
`define LLEC_CONSTS_SVH
// Register byte addresses
`define LLEC_ADDR_FLAGS 12'h000
`define LLEC_ADDR_LOLCNT 12'h004
`define LLEC_ADDR_REFDIV 12'h008
`define LLEC_ADDR_FBMOD 12'h00C
`define LLEC_ADDR_IRQMASK 12'h010
// Flag bit positions
`define LLEC_BIT_LOL 0
`define LLEC_BIT_LMT 1
`define LLEC_BIT_HOLD 2
`define LLEC_BIT_STCH 3
// Field positions, counter limits, state and order codes, reset values
`define LLEC_FBMOD_EN_BIT 7
`define LLEC_CNT_MAX 4'hF
`define LLEC_CNT_ZERO 4'h0
`define LLEC_CNT_THRESH 4'h8
`define LLEC_REFDIV_RST 3'h1
`define LLEC_FBMOD_EN_RST 1'b1
`define LLEC_FBMOD_ORD_RST 2'h1
`define LLEC_STATE_HOLDOVER 3'h2
`define LLEC_MASK_RST 4'h0
`define LLEC_ORDER_RSVD 2'h3
// Field upper bits and reset values
`define LLEC_CNT_MSB 3
`define LLEC_REFDIV_MSB 2
`define LLEC_ORD_MSB 1
`define LLEC_RSVD_LSB 8
`define LLEC_FLAGS_RST 4'h0
`define LLEC_STATE_RST 3'h0
`define LLEC_CNT_STEP 4'h1
`define LLEC_RDATA_ZERO 32'h0000_0000
// Divide ratio one-hot codes toward the analog loop
`define LLEC_ONEHOT_BYP 5'h01
`define LLEC_ONEHOT_DIV2 5'h02
`define LLEC_ONEHOT_DIV4 5'h04
`define LLEC_ONEHOT_DIV8 5'h08
`define LLEC_ONEHOT_DIV16 5'h10
`define LLEC_FBMOD_OUT_EN_RST 1'b0
`define LLEC_FBMOD_OUT_INT_RST 1'b1
`define LLEC_FBMOD_OUT_ORD_RST 2'h0
`endif

// ---- llec_pkg.sv ----
package llec_pkg;
    typedef enum logic [2:0] {
        LLEC_REF_BYPASS = 3'h0,
        LLEC_REF_DIV2 = 3'h1,
        LLEC_REF_DIV4 = 3'h2,
        LLEC_REF_DIV8 = 3'h3,
        LLEC_REF_DIV16 = 3'h4
    } llec_refdiv_t;
    typedef enum logic [1:0] {
        LLEC_ORD_INT = 2'h0,
        LLEC_ORD_FIRST = 2'h1,
        LLEC_ORD_SECOND = 2'h2
    } llec_order_t;
endpackage

// ---- llec_regs.sv ----
`timescale 1ns/1ps
`include "llec_consts.svh"
//Contract
// - Any loop state change sets flag bit 3; write one clears it.
// - Entry into holdover sets flag bit 2; write one or soft reset clears it.
// - Locked-to-unlocked transition sets flag bit 0; write one clears.
// - Flag bit 1 set while count exceeds alarm threshold; sticky.
// - Write one to bit 1 ignored while count still exceeds threshold.
// - Four-bit counter increments on every falling edge of lock status.
// - Counter saturates at all ones, never wraps.
// - Software write loads counter; zero clears, nonzero presets.
// - Counter writes accepted only when not clock gated nor soft reset.
// - Reference divider code 0 bypasses; 1..4 divide by 2,4,8,16.
// - Divider applies to reference picked by the analog-loop selector.
// - Bit 7 enables modulator; zero gives constant integer division.
// - Order field bits 1:0: integer, first, second; three reserved.
// - One-bit lock status, one means locked; its fall drives events.
// - Three-bit loop state encoding; any change sets state-change flag.
module llec_regs
    import llec_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic lock_status,
    input wire logic [2:0] loop_state,
    input wire logic loop_software_reset,
    input wire logic loop_clock_gated,
    input wire logic ref_select,
    input wire logic ref_external,
    input wire logic ref_clkin,
    output logic ref_selected,
    output logic [4:0] ref_div_ratio_onehot,
    output logic fb_modulator_enable,
    output logic [1:0] fb_modulator_order,
    output logic fb_integer_mode,
    output logic irq
);
    // ****************************************
    // Bus decode
    // ****************************************
    logic wr_en;
    logic sel_flags;
    logic sel_cnt;
    logic sel_refdiv;
    logic sel_fbmod;
    logic sel_mask;
    logic [3:0] loop_event_flags;
    logic [3:0] loss_of_lock_count;
    logic [2:0] converter_ref_divider_cfg;
    logic fb_en;
    logic [1:0] fb_order;
    logic [3:0] irq_mask;
    logic lock_q;
    logic [2:0] state_q;
    logic hist_valid;
    logic lol_event;
    logic stch_event;
    logic hold_event;
    logic over_thresh;
    logic cnt_wr_ok;

    // Write-one-to-clear: a one in the write data drops the flag
    function automatic logic llec_w1c(input logic cur, input logic clr);
        return cur & ~clr;
    endfunction

    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign sel_flags = (paddr == `LLEC_ADDR_FLAGS);
    assign sel_cnt = (paddr == `LLEC_ADDR_LOLCNT);
    assign sel_refdiv = (paddr == `LLEC_ADDR_REFDIV);
    assign sel_fbmod = (paddr == `LLEC_ADDR_FBMOD);
    assign sel_mask = (paddr == `LLEC_ADDR_IRQMASK);
    assign pslverr = psel && penable && !(sel_flags || sel_cnt || sel_refdiv || sel_fbmod || sel_mask);

    // Reserved bits read as zero
    always_comb begin
        prdata = `LLEC_RDATA_ZERO;
        if (sel_flags) begin
            prdata[`LLEC_BIT_STCH:0] = loop_event_flags;
        end else if (sel_cnt) begin
            prdata[`LLEC_CNT_MSB:0] = loss_of_lock_count;
        end else if (sel_refdiv) begin
            prdata[`LLEC_REFDIV_MSB:0] = converter_ref_divider_cfg;
        end else if (sel_fbmod) begin
            prdata[`LLEC_FBMOD_EN_BIT] = fb_en;
            prdata[`LLEC_ORD_MSB:0] = fb_order;
        end else if (sel_mask) begin
            prdata[`LLEC_BIT_STCH:0] = irq_mask;
        end
    end

    // ****************************************
    // Event detection
    // ****************************************
    // Inputs come from loop logic on this clock; no synchroniser needed
    always_ff @(posedge clk) begin
        if (rst || loop_software_reset) begin
            lock_q <= 1'b0;
            state_q <= `LLEC_STATE_RST;
            hist_valid <= 1'b0;
        end else begin
            lock_q <= lock_status;
            state_q <= loop_state;
            hist_valid <= 1'b1;
        end
    end

    assign lol_event = hist_valid && lock_q && !lock_status;
    assign stch_event = hist_valid && (state_q != loop_state);
    assign hold_event = stch_event && (loop_state == `LLEC_STATE_HOLDOVER);
    assign over_thresh = loss_of_lock_count > `LLEC_CNT_THRESH;
    assign cnt_wr_ok = !loop_clock_gated && !loop_software_reset;

    // ****************************************
    // Sticky flags, set wins over clear
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst || loop_software_reset) begin
            loop_event_flags <= `LLEC_FLAGS_RST;
        end else begin
            if (wr_en && sel_flags) begin
                loop_event_flags[`LLEC_BIT_LOL] <= llec_w1c(loop_event_flags[`LLEC_BIT_LOL], pwdata[`LLEC_BIT_LOL]);
                loop_event_flags[`LLEC_BIT_HOLD] <= llec_w1c(loop_event_flags[`LLEC_BIT_HOLD], pwdata[`LLEC_BIT_HOLD]);
                loop_event_flags[`LLEC_BIT_STCH] <= llec_w1c(loop_event_flags[`LLEC_BIT_STCH], pwdata[`LLEC_BIT_STCH]);
                // Limit flag holds while the excursion lasts
                if (!over_thresh) begin
                    loop_event_flags[`LLEC_BIT_LMT] <= llec_w1c(loop_event_flags[`LLEC_BIT_LMT],
                        pwdata[`LLEC_BIT_LMT]);
                end
            end
            if (lol_event) begin
                loop_event_flags[`LLEC_BIT_LOL] <= 1'b1;
            end
            if (hold_event) begin
                loop_event_flags[`LLEC_BIT_HOLD] <= 1'b1;
            end
            if (stch_event) begin
                loop_event_flags[`LLEC_BIT_STCH] <= 1'b1;
            end
            if (over_thresh) begin
                loop_event_flags[`LLEC_BIT_LMT] <= 1'b1;
            end
        end
    end

    // ****************************************
    // Loss-of-lock counter
    // ****************************************
    // Software preset takes priority over a coincident lock loss
    always_ff @(posedge clk) begin
        if (rst || loop_software_reset) begin
            loss_of_lock_count <= `LLEC_CNT_ZERO;
        end else if (wr_en && sel_cnt && cnt_wr_ok) begin
            loss_of_lock_count <= pwdata[`LLEC_CNT_MSB:0];
        end else if (lol_event && loss_of_lock_count != `LLEC_CNT_MAX) begin
            loss_of_lock_count <= loss_of_lock_count + `LLEC_CNT_STEP;
        end
    end

    // ****************************************
    // Configuration
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            converter_ref_divider_cfg <= `LLEC_REFDIV_RST;
            fb_en <= `LLEC_FBMOD_EN_RST;
            fb_order <= `LLEC_FBMOD_ORD_RST;
            irq_mask <= `LLEC_MASK_RST;
        end else if (wr_en) begin
            if (sel_refdiv) begin
                converter_ref_divider_cfg <= pwdata[`LLEC_REFDIV_MSB:0];
            end
            if (sel_fbmod) begin
                fb_en <= pwdata[`LLEC_FBMOD_EN_BIT];
                fb_order <= pwdata[`LLEC_ORD_MSB:0];
            end
            if (sel_mask) begin
                irq_mask <= pwdata[`LLEC_BIT_STCH:0];
            end
        end
    end

    // Registered outputs toward the analog loop
    always_ff @(posedge clk) begin
        if (rst) begin
            ref_div_ratio_onehot <= `LLEC_ONEHOT_DIV2;
            fb_modulator_enable <= `LLEC_FBMOD_OUT_EN_RST;
            fb_modulator_order <= `LLEC_FBMOD_OUT_ORD_RST;
            fb_integer_mode <= `LLEC_FBMOD_OUT_INT_RST;
        end else begin
            // Unused codes fall back to bypass rather than an odd ratio
            case (converter_ref_divider_cfg)
                LLEC_REF_BYPASS: ref_div_ratio_onehot <= `LLEC_ONEHOT_BYP;
                LLEC_REF_DIV2: ref_div_ratio_onehot <= `LLEC_ONEHOT_DIV2;
                LLEC_REF_DIV4: ref_div_ratio_onehot <= `LLEC_ONEHOT_DIV4;
                LLEC_REF_DIV8: ref_div_ratio_onehot <= `LLEC_ONEHOT_DIV8;
                LLEC_REF_DIV16: ref_div_ratio_onehot <= `LLEC_ONEHOT_DIV16;
                default: ref_div_ratio_onehot <= `LLEC_ONEHOT_BYP;
            endcase
            fb_modulator_enable <= fb_en;
            fb_integer_mode <= !fb_en;
            // Reserved order falls back to integer so the divider stays sane
            fb_modulator_order <= (fb_order == `LLEC_ORDER_RSVD) ? LLEC_ORD_INT : fb_order;
        end
    end

    // Selected reference handed to the divider
    assign ref_selected = ref_select ? ref_external : ref_clkin;

    // ****************************************
    // Interrupt
    // ****************************************
    // Level output; stays high until software clears or masks the flag
    assign irq = |(loop_event_flags & irq_mask);

    // ****************************************
    // Checks
    // ****************************************
    lol_flag_a: assert property (@(posedge clk) disable iff (rst || loop_software_reset)
        lol_event |=> loop_event_flags[`LLEC_BIT_LOL]) else $error("lol flag not set");
    stch_flag_a: assert property (@(posedge clk) disable iff (rst || loop_software_reset)
        stch_event |=> loop_event_flags[`LLEC_BIT_STCH]) else $error("state flag not set");
    hold_flag_a: assert property (@(posedge clk) disable iff (rst || loop_software_reset)
        hold_event |=> loop_event_flags[`LLEC_BIT_HOLD]) else $error("holdover flag not set");
    lmt_flag_a: assert property (@(posedge clk) disable iff (rst || loop_software_reset)
        over_thresh |=> loop_event_flags[`LLEC_BIT_LMT]) else $error("limit flag not set");
    lmt_hold_a: assert property (@(posedge clk) disable iff (rst || loop_software_reset)
        (loop_event_flags[`LLEC_BIT_LMT] && over_thresh) |=> loop_event_flags[`LLEC_BIT_LMT])
        else $error("limit flag cleared early");
    cnt_inc_a: assert property (@(posedge clk) disable iff (rst || loop_software_reset)
        (lol_event && !(wr_en && sel_cnt) && loss_of_lock_count != `LLEC_CNT_MAX)
        |=> loss_of_lock_count == $past(loss_of_lock_count) + 4'h1) else $error("count not incremented");
    cnt_sat_a: assert property (@(posedge clk) disable iff (rst || loop_software_reset)
        (loss_of_lock_count == `LLEC_CNT_MAX && !(wr_en && sel_cnt)) |=> loss_of_lock_count == `LLEC_CNT_MAX)
        else $error("count wrapped");
    cnt_load_a: assert property (@(posedge clk) disable iff (rst || loop_software_reset)
        (wr_en && sel_cnt && cnt_wr_ok) |=> loss_of_lock_count == $past(pwdata[3:0]))
        else $error("count load failed");
    cnt_block_a: assert property (@(posedge clk) disable iff (rst || loop_software_reset)
        (wr_en && sel_cnt && loop_clock_gated && !lol_event) |=> $stable(loss_of_lock_count))
        else $error("gated write took effect");
    fb_en_a: assert property (@(posedge clk) disable iff (rst)
        (wr_en && sel_fbmod) |=> ##1 fb_modulator_enable == $past(pwdata[`LLEC_FBMOD_EN_BIT], 2))
        else $error("modulator enable mismatch");

    // ****************************************
    // Sequences seen from the pins
    // ****************************************
    // Built from raw inputs, not from the internal strobes,
    // so a broken edge detector cannot hide behind its own output
    sequence lock_drop_s;
        (!rst && !loop_software_reset && lock_status) ##1 !lock_status;
    endsequence

    sequence state_move_s;
        (!rst && !loop_software_reset) ##1 (loop_state != $past(loop_state));
    endsequence

    sequence hold_entry_s;
        state_move_s ##0 (loop_state == `LLEC_STATE_HOLDOVER);
    endsequence

    sequence flag_write_s;
        (psel && !penable && pwrite && sel_flags) ##1 wr_en;
    endsequence

    // ****************************************
    // Pin-level checks
    // ****************************************
    lol_pin_a: assert property (@(posedge clk) disable iff (rst || loop_software_reset)
        lock_drop_s |=> loop_event_flags[`LLEC_BIT_LOL]) else $error("lock drop missed");

    cnt_pin_a: assert property (@(posedge clk) disable iff (rst || loop_software_reset)
        (lock_drop_s ##0 (!(wr_en && sel_cnt) && loss_of_lock_count != `LLEC_CNT_MAX))
        |=> loss_of_lock_count == $past(loss_of_lock_count) + `LLEC_CNT_STEP)
        else $error("lock drop not counted");

    stch_pin_a: assert property (@(posedge clk) disable iff (rst || loop_software_reset)
        state_move_s |=> loop_event_flags[`LLEC_BIT_STCH]) else $error("state move missed");

    hold_pin_a: assert property (@(posedge clk) disable iff (rst || loop_software_reset)
        hold_entry_s |=> loop_event_flags[`LLEC_BIT_HOLD]) else $error("holdover entry missed");

    // ****************************************
    // Clear and keep checks
    // ****************************************
    lol_clr_a: assert property (@(posedge clk) disable iff (rst || loop_software_reset)
        (flag_write_s ##0 (pwdata[`LLEC_BIT_LOL] && !lol_event)) |=> !loop_event_flags[`LLEC_BIT_LOL])
        else $error("lol flag not cleared");

    stch_clr_a: assert property (@(posedge clk) disable iff (rst || loop_software_reset)
        (flag_write_s ##0 (pwdata[`LLEC_BIT_STCH] && !stch_event)) |=> !loop_event_flags[`LLEC_BIT_STCH])
        else $error("state flag not cleared");

    hold_keep_a: assert property (@(posedge clk) disable iff (rst || loop_software_reset)
        (loop_event_flags[`LLEC_BIT_HOLD] && !(wr_en && sel_flags && pwdata[`LLEC_BIT_HOLD]))
        |=> loop_event_flags[`LLEC_BIT_HOLD])
        else $error("holdover flag lost");

    lmt_clr_a: assert property (@(posedge clk) disable iff (rst || loop_software_reset)
        (flag_write_s ##0 (pwdata[`LLEC_BIT_LMT] && !over_thresh)) |=> !loop_event_flags[`LLEC_BIT_LMT])
        else $error("limit flag not cleared");

    cnt_keep_a: assert property (@(posedge clk) disable iff (rst || loop_software_reset)
        (!lol_event && !(wr_en && sel_cnt)) |=> $stable(loss_of_lock_count))
        else $error("count moved without cause");

    soft_blk_a: assert property (@(posedge clk) disable iff (rst)
        (wr_en && sel_cnt && loop_software_reset) |=> loss_of_lock_count == `LLEC_CNT_ZERO)
        else $error("write in soft reset took effect");

    // ****************************************
    // Configuration checks
    // ****************************************
    refdiv_rsvd_a: assert property (@(posedge clk) disable iff (rst)
        (converter_ref_divider_cfg > LLEC_REF_DIV16) |=> ref_div_ratio_onehot == `LLEC_ONEHOT_BYP)
        else $error("unused divider code not bypassed");

    refdiv_one_a: assert property (@(posedge clk) disable iff (rst)
        $onehot(ref_div_ratio_onehot)) else $error("divide ratio not one-hot");

    fb_mode_a: assert property (@(posedge clk) disable iff (rst)
        fb_integer_mode != fb_modulator_enable) else $error("integer mode and enable agree");

    ord_rsvd_a: assert property (@(posedge clk) disable iff (rst)
        (fb_order == `LLEC_ORDER_RSVD) |=> fb_modulator_order == LLEC_ORD_INT)
        else $error("reserved order driven out");

    rd_rsvd_a: assert property (@(posedge clk) disable iff (rst)
        (psel && !pwrite) |-> prdata[$bits(prdata) - 1:`LLEC_RSVD_LSB] == '0)
        else $error("reserved read bits not zero");

    irq_mask_a: assert property (@(posedge clk) disable iff (rst)
        (irq_mask == `LLEC_MASK_RST) |-> !irq) else $error("irq while fully masked");
endmodule // llec_regs

// ---- tb.sv ----
`timescale 1ns/1ps
`include "llec_consts.svh"
module tb;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic lock_status = 1, loop_software_reset = 0, loop_clock_gated = 0;
    logic ref_select = 0, ref_external = 0, ref_clkin = 0, ref_selected;
    logic fb_modulator_enable, fb_integer_mode, irq;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdat;
    logic rerr;
    logic [2:0] loop_state = 0;
    logic [4:0] ref_div_ratio_onehot;
    logic [1:0] fb_modulator_order;
    int num_errors = 0, checked = 0;
    llec_regs llec_regs_inst (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .lock_status, .loop_state, .loop_software_reset, .loop_clock_gated, .ref_select,
        .ref_external, .ref_clkin, .ref_selected, .ref_div_ratio_onehot, .fb_modulator_enable,
        .fb_modulator_order, .fb_integer_mode, .irq);
    initial forever #5 clk = ~clk;
    // ****************
    // Shared tasks
    // ****************
    task automatic close_out();
        if (num_errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
        apb(0, a, 0);
        chk(n, e, rdat);
    endtask
    task automatic loss();
        @(posedge clk);
        lock_status <= 0;
        @(posedge clk);
        lock_status <= 1;
        repeat (2) @(posedge clk);
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_reset();
        rdc("flags", `LLEC_ADDR_FLAGS, 0);
        rdc("count", `LLEC_ADDR_LOLCNT, 0);
        rdc("refdiv", `LLEC_ADDR_REFDIV, 32'h01);
        rdc("fbmod", `LLEC_ADDR_FBMOD, 32'h81);
        rdc("mask", `LLEC_ADDR_IRQMASK, 0);
        chk("slverr", 0, rerr);
        chk("onehot", 32'h02, ref_div_ratio_onehot);
        chk("fb_en", 1, fb_modulator_enable);
        chk("fb_int", 0, fb_integer_mode);
        chk("fb_ord", 1, fb_modulator_order);
        apb(0, 12'h014, 32'hFFFF_FFFF);
        chk("unmapped", 0, rdat);
        chk("slverr", 1, rerr);
        apb(1, 12'h014, 32'hFFFF_FFFF);
        chk("slverr", 1, rerr);
        rdc("mask", `LLEC_ADDR_IRQMASK, 0);
    endtask
    task automatic t_lol();
        loss();
        rdc("count", `LLEC_ADDR_LOLCNT, 1);
        rdc("flags", `LLEC_ADDR_FLAGS, 1);
        apb(1, `LLEC_ADDR_FLAGS, 0);
        rdc("flags", `LLEC_ADDR_FLAGS, 1);
        chk("irq", 0, irq);
        apb(1, `LLEC_ADDR_IRQMASK, 32'hF);
        @(posedge clk);
        chk("irq", 1, irq);
        apb(1, `LLEC_ADDR_FLAGS, 1);
        rdc("flags", `LLEC_ADDR_FLAGS, 0);
        chk("irq", 0, irq);
    endtask
    task automatic t_limit();
        apb(1, `LLEC_ADDR_LOLCNT, `LLEC_CNT_THRESH);
        loss();
        rdc("count", `LLEC_ADDR_LOLCNT, 9);
        rdc("flags", `LLEC_ADDR_FLAGS, 3);
        apb(1, `LLEC_ADDR_FLAGS, 32'hF);
        rdc("flags", `LLEC_ADDR_FLAGS, 2);
        apb(1, `LLEC_ADDR_LOLCNT, 32'hE);
        loss();
        loss();
        rdc("count", `LLEC_ADDR_LOLCNT, 32'hF);
        apb(1, `LLEC_ADDR_LOLCNT, 0);
        rdc("count", `LLEC_ADDR_LOLCNT, 0);
        apb(1, `LLEC_ADDR_FLAGS, 32'hF);
        rdc("flags", `LLEC_ADDR_FLAGS, 0);
        apb(1, `LLEC_ADDR_LOLCNT, 32'hFF);
        rdc("count", `LLEC_ADDR_LOLCNT, 32'hF);
        apb(1, `LLEC_ADDR_LOLCNT, 0);
    endtask
    task automatic t_block();
        loop_clock_gated <= 1;
        apb(1, `LLEC_ADDR_LOLCNT, 5);
        rdc("count", `LLEC_ADDR_LOLCNT, 0);
        loop_clock_gated <= 0;
        loop_software_reset <= 1;
        apb(1, `LLEC_ADDR_LOLCNT, 5);
        rdc("count", `LLEC_ADDR_LOLCNT, 0);
        loop_software_reset <= 0;
        apb(1, `LLEC_ADDR_LOLCNT, 5);
        rdc("count", `LLEC_ADDR_LOLCNT, 5);
        apb(1, `LLEC_ADDR_LOLCNT, 0);
    endtask
    task automatic t_state();
        for (int s = 1; s <= 6; s++) begin
            loop_state <= 3'(s % 6);
            rdc("flags", `LLEC_ADDR_FLAGS, s == 2 ? 32'hC : 32'h8);
            apb(1, `LLEC_ADDR_FLAGS, 32'hF);
        end
    endtask
    task automatic t_refdiv();
        for (int i = 0; i < 8; i++) begin
            ref_select <= i[0];
            ref_external <= i[1];
            ref_clkin <= !i[1];
            apb(1, `LLEC_ADDR_REFDIV, 32'hF8 | i);
            rdc("refdiv", `LLEC_ADDR_REFDIV, i);
            chk("onehot", i < 5 ? 32'h1 << i : 32'h1, ref_div_ratio_onehot);
            chk("ref_sel", i[0] ? i[1] : !i[1], ref_selected);
        end
        // Leave a ratio that keeps the converter reference in range
        apb(1, `LLEC_ADDR_REFDIV, `LLEC_REFDIV_RST);
        rdc("refdiv", `LLEC_ADDR_REFDIV, `LLEC_REFDIV_RST);
    endtask
    task automatic t_fb();
        for (int i = 0; i < 8; i++) begin
            apb(1, `LLEC_ADDR_FBMOD, 32'h7C | (i[2] << 7) | i[1:0]);
            rdc("fbmod", `LLEC_ADDR_FBMOD, (i[2] << 7) | i[1:0]);
            chk("fb_en", i[2], fb_modulator_enable);
            chk("fb_int", !i[2], fb_integer_mode);
            chk("fb_ord", i[1:0] == 3 ? 0 : i[1:0], fb_modulator_order);
        end
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst <= 0;
        t_reset();
        t_lol();
        t_limit();
        t_block();
        t_state();
        t_refdiv();
        t_fb();
        close_out();
    end
    // Far beyond the 82 transfers above
    initial begin
        #200us;
        num_errors++;
        close_out();
    end
endmodule // tb
